//--- fps_deglitch.sv
`timescale 1ns/10ps
module fps_deglitch
  import fps_pkg::*;
#(
  parameter int unsigned CYCLES = 8
)
(
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  // fault level
  fps_dgl_if.owner  dgl
);
  logic [DGL_W-1:0] cnt_q;
  logic             filt_q;
  wire              at_end = (cnt_q == DGL_W'(CYCLES - 1));

  // filter asserts after a continuous run, releases at once
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i || !dgl.raw)
    begin
      cnt_q  <= '0;
      filt_q <= 1'b0;
    end
    else if (at_end)
      filt_q <= 1'b1;
    else
      cnt_q <= cnt_q + 1'b1;
  end

  assign dgl.filt = filt_q;
endmodule : fps_deglitch

//--- fps_dgl_if.sv
`timescale 1ns/10ps
// raw fault level in, filtered level out
interface fps_dgl_if;
  logic raw;
  logic filt;
  modport owner (input raw, output filt);
  modport user  (output raw, input filt);
endinterface : fps_dgl_if

//--- fps_mcu_model.sv
`timescale 1ns/10ps
module fps_mcu_model
(
  // clock
  input  wire logic        core_clk_i,
  // apb answer
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // apb request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata
);
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end

  // setup, access held until pready, then one idle cycle
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk_i);
    penable <= 1'b1;
    do
      @(posedge core_clk_i);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk_i);
  endtask : xfer
endmodule : fps_mcu_model

//--- fps_pkg.sv
package fps_pkg;

  // channel count
  localparam int unsigned NUM_CH = 5;

  // register byte offsets on the bus
  localparam logic [7:0] REG_QUICK_STAT = 8'h00;
  localparam logic [7:0] REG_CH_STAT    = 8'h04;
  localparam logic [7:0] REG_DEV_STAT   = 8'h08;
  localparam logic [7:0] REG_CH_CTRL    = 8'h0c;
  localparam logic [7:0] REG_OUT_CTRL   = 8'h10;
  localparam logic [7:0] REG_CONFIG     = 8'h14;
  localparam logic [7:0] REG_OUT_STATE  = 8'h18;

  // quick status layout
  localparam int unsigned QS_WARN_LSB = 0;
  localparam int unsigned QS_SHUT_LSB = 8;
  localparam int unsigned QS_PUMP_BIT = 16;
  localparam int unsigned DSF_BIT     = 31;

  // channel status / control layout
  localparam int unsigned CH_SEL_LSB  = 8;
  localparam int unsigned CH_SEL_W    = 3;
  localparam int unsigned CS_WARN_BIT = 0;
  localparam int unsigned CS_SHUT_BIT = 1;
  localparam int unsigned CC_ON_BIT   = 0;

  // device status layout
  localparam int unsigned DS_UV_BIT   = 0;
  localparam int unsigned DS_OV_BIT   = 1;

  // config layout
  localparam int unsigned CFG_WSEL_BIT = 0;
  localparam int unsigned CFG_FAIL_BIT = 1;

  // deglitch and restart timing
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned TEMP_DGL_NS    = 5000;
  localparam int unsigned SUPPLY_DGL_NS  = 3500;
  localparam int unsigned PUMP_DGL_NS    = 4000;
  localparam int unsigned RESTART_MS     = 64;
  localparam int unsigned TEMP_DGL_CYC   = TEMP_DGL_NS * CLK_MHZ / 1000;
  localparam int unsigned SUPPLY_DGL_CYC = SUPPLY_DGL_NS * CLK_MHZ / 1000;
  localparam int unsigned PUMP_DGL_CYC   = PUMP_DGL_NS * CLK_MHZ / 1000;
  localparam int unsigned RESTART_CYC    = RESTART_MS * CLK_MHZ * 1000;
  localparam int unsigned DGL_W          = 10;

endpackage : fps_pkg

//--- fps_supervisor.sv
`timescale 1ns/10ps
// Behaviour
// - a warning leaves the output untouched and only sets its flag
// - shutdown temperature turns the output off after deglitch and sets its flag on the same edge
// - warning and shutdown appear in quick status and channel status
// - threshold select 0 (reset) uses high warning threshold, 1 low
// - warning flag clears after temperature drops and channel status read
// - normal mode: shutdown output stays off until cleared and on written, or a mode transition
// - shutdown flag latched until condition gone and channel status read
// - fail mode: shutdown output restarts only after a mode transition
// - deglitched undervoltage sets summary flag and undervoltage flag
// - normal mode: undervoltage restart needs clear condition plus on write
// - undervoltage flag clears after condition gone and device status read
// - fail mode: undervoltage restart by autorestart, no master command
// - autorestart attempts spaced by the 64 ms period
// - load dump keeps every output off
// - overvoltage sets summary flag and overvoltage flag
// - overvoltage flag clears after condition gone and device status read
// - before pump valid, turn-on deferred then executed at once
// - pump out of range past deglitch disables all outputs
// - deglitched pump fault sets summary flag and quick status pump flag
// - turn-on during pump fault runs with overcurrent windows once valid
// - pump flag clears after fault gone and quick status read
module fps_supervisor
  import fps_pkg::*;
#(
  parameter int unsigned RESTART_CYCLES = RESTART_CYC
)
(
  // clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              rst_n_i,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // analog fault indications (asynchronous)
  input  wire logic [NUM_CH-1:0] warn_hi_i,
  input  wire logic [NUM_CH-1:0] warn_lo_i,
  input  wire logic [NUM_CH-1:0] temp_shut_i,
  input  wire logic              uv_i,
  input  wire logic              ov_i,
  input  wire logic              load_dump_i,
  input  wire logic              pump_bad_i,
  // mode machine
  input  wire logic              fail_mode_i,
  input  wire logic              mode_change_i,
  // outputs
  output logic      [NUM_CH-1:0] out_on_o,
  output logic      [NUM_CH-1:0] high_overcurrent_window_start_o
);
  // synchronisers
  localparam int unsigned SW = 3 * NUM_CH + 4;
  logic [SW-1:0] s1_q, s2_q;
  always_ff @(posedge core_clk_i)
  begin
    s1_q <= {warn_hi_i, warn_lo_i, temp_shut_i, uv_i, ov_i, load_dump_i, pump_bad_i};
    s2_q <= s1_q;
  end
  wire [NUM_CH-1:0] whi  = s2_q[SW-1 -: NUM_CH];
  wire [NUM_CH-1:0] wlo  = s2_q[2*NUM_CH+3 -: NUM_CH];
  wire [NUM_CH-1:0] tsh  = s2_q[NUM_CH+3 -: NUM_CH];
  wire              uv_s = s2_q[3];
  wire              ov_s = s2_q[2];
  wire              ld_s = s2_q[1];
  wire              cp_s = s2_q[0];

  // deglitch filters
  fps_dgl_if dg_uv ();
  fps_dgl_if dg_ov ();
  fps_dgl_if dg_cp ();
  fps_dgl_if dg_ts [NUM_CH] ();
  assign dg_uv.raw = uv_s;
  assign dg_ov.raw = ov_s;
  assign dg_cp.raw = cp_s;
  fps_deglitch #(.CYCLES(SUPPLY_DGL_CYC)) u_dg_uv (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .dgl(dg_uv));
  fps_deglitch #(.CYCLES(SUPPLY_DGL_CYC)) u_dg_ov (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .dgl(dg_ov));
  fps_deglitch #(.CYCLES(PUMP_DGL_CYC)) u_dg_cp (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .dgl(dg_cp));
  logic [NUM_CH-1:0] ts_f;
  for (genvar g = 0; g < NUM_CH; g++)
  begin : g_ts
    assign dg_ts[g].raw = tsh[g];
    assign ts_f[g]      = dg_ts[g].filt;
    fps_deglitch #(.CYCLES(TEMP_DGL_CYC)) u_dg_ts (.core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i), .dgl(dg_ts[g]));
  end
  wire uv_f = dg_uv.filt;
  wire ov_f = dg_ov.filt;
  wire cp_f = dg_cp.filt;

  // bus decode
  logic              wsel_q;
  logic [CH_SEL_W-1:0] chsel_q;
  wire               acc    = psel && penable;
  wire               wr     = acc && pwrite;
  wire               rd     = acc && !pwrite;
  wire               hit_qs = paddr == REG_QUICK_STAT;
  wire               hit_cs = paddr == REG_CH_STAT;
  wire               hit_ds = paddr == REG_DEV_STAT;
  wire               hit_cc = paddr == REG_CH_CTRL;
  wire               hit_oc = paddr == REG_OUT_CTRL;
  wire               hit_cf = paddr == REG_CONFIG;
  wire               hit_os = paddr == REG_OUT_STATE;
  wire               mapped = hit_qs | hit_cs | hit_ds | hit_cc | hit_oc | hit_cf | hit_os;
  wire [CH_SEL_W-1:0] sel_ch = pwdata[CH_SEL_LSB +: CH_SEL_W];
  wire               sel_ok = sel_ch < CH_SEL_W'(NUM_CH);
  wire               rd_qs  = rd && hit_qs;
  wire               rd_ds  = rd && hit_ds;
  wire [NUM_CH-1:0]  rd_cs  = (rd && hit_cs) ? (NUM_CH'(1) << chsel_q) : '0;

  // on command: channel control writes one channel, output control writes all
  logic [NUM_CH-1:0] on_wr_mask;
  logic [NUM_CH-1:0] on_wr_val;
  always_comb
  begin
    on_wr_mask = '0;
    on_wr_val  = '0;
    if (wr && hit_cc && sel_ok)
    begin
      on_wr_mask = NUM_CH'(1) << sel_ch;
      on_wr_val  = pwdata[CC_ON_BIT] ? on_wr_mask : '0;
    end
    else if (wr && hit_oc)
    begin
      on_wr_mask = '1;
      on_wr_val  = pwdata[NUM_CH-1:0];
    end
  end

  // fault state
  logic [NUM_CH-1:0] warn_q, shut_q, ts_lock_q, cmd_q, uv_lock_q, out_q, high_overcurrent_window_q;
  logic              uv_q, ov_q, cp_q, fail_q, uv_seen_q;
  logic [31:0]       rst_cnt_q;
  wire  [NUM_CH-1:0] warn_now = wsel_q ? wlo : whi;
  wire               device_fault_summary      = uv_q | ov_q | cp_q;
  wire               global_off = uv_f | ld_s | cp_f | ov_f;
  wire               auto_tick = fail_q && uv_seen_q && !uv_f &&
                                 (rst_cnt_q == 32'(RESTART_CYCLES - 1));
  wire  [NUM_CH-1:0] set_on   = on_wr_mask & on_wr_val;
  // restart clears lock: on write in normal mode, mode change for temperature in fail mode
  wire  [NUM_CH-1:0] ts_unlock = mode_change_i ? ~ts_f :
                                 (fail_q ? '0 : set_on & ~ts_f);
  wire  [NUM_CH-1:0] uv_unlock = uv_f ? '0 :
                                 (fail_q ? (auto_tick ? '1 : '0) : set_on);
  wire  [NUM_CH-1:0] ts_lock_d = (ts_lock_q & ~ts_unlock) | ts_f;
  wire  [NUM_CH-1:0] uv_lock_d = uv_f ? cmd_q | uv_lock_q : uv_lock_q & ~uv_unlock;
  wire  [NUM_CH-1:0] cmd_d     = (cmd_q & ~on_wr_mask) | on_wr_val;
  // pump invalid defers turn-on; output follows once it settles
  wire  [NUM_CH-1:0] out_d     = global_off ? '0 : cmd_q & ~ts_lock_d & ~uv_lock_q;

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      warn_q    <= '0;
      shut_q    <= '0;
      ts_lock_q <= '0;
      uv_lock_q <= '0;
      cmd_q     <= '0;
      out_q     <= '0;
      high_overcurrent_window_q    <= '0;
      uv_q      <= 1'b0;
      ov_q      <= 1'b0;
      cp_q      <= 1'b0;
      fail_q    <= 1'b0;
      uv_seen_q <= 1'b0;
      rst_cnt_q <= '0;
      wsel_q    <= 1'b0;
      chsel_q   <= '0;
    end
    else
    begin
      // set wins over read clear
      warn_q    <= warn_now | (warn_q & ~rd_cs);
      shut_q    <= ts_f | (shut_q & ~rd_cs);
      uv_q      <= uv_f | (uv_q & ~rd_ds);
      ov_q      <= ov_f | (ov_q & ~rd_ds);
      cp_q      <= cp_f | (cp_q & ~rd_qs);
      ts_lock_q <= ts_lock_d;
      uv_lock_q <= uv_lock_d;
      cmd_q     <= cmd_d;
      out_q     <= out_d;
      high_overcurrent_window_q    <= out_d & ~out_q;
      fail_q    <= fail_mode_i;
      uv_seen_q <= (uv_seen_q | uv_f) & ~(auto_tick | ~fail_q);
      rst_cnt_q <= (uv_f || !fail_q || auto_tick) ? '0 : rst_cnt_q + 32'h1;
      if (wr && hit_cf)
        wsel_q <= pwdata[CFG_WSEL_BIT];
      if (wr && hit_cs && sel_ok)
        chsel_q <= sel_ch;
    end
  end

  // read data
  logic [31:0] rdata;
  always_comb
  begin
    rdata = '0;
    if (hit_qs)
    begin
      rdata[QS_WARN_LSB +: NUM_CH] = warn_q;
      rdata[QS_SHUT_LSB +: NUM_CH] = shut_q;
      rdata[QS_PUMP_BIT]           = cp_q;
      rdata[DSF_BIT]               = device_fault_summary;
    end
    else if (hit_cs)
    begin
      rdata[CS_WARN_BIT] = warn_q[chsel_q];
      rdata[CS_SHUT_BIT] = shut_q[chsel_q];
      rdata[CH_SEL_LSB +: CH_SEL_W] = chsel_q;
      rdata[DSF_BIT]     = device_fault_summary;
    end
    else if (hit_ds)
    begin
      rdata[DS_UV_BIT] = uv_q;
      rdata[DS_OV_BIT] = ov_q;
      rdata[DSF_BIT]   = device_fault_summary;
    end
    else if (hit_cc || hit_oc)
      rdata[NUM_CH-1:0] = cmd_q;
    else if (hit_cf)
    begin
      rdata[CFG_WSEL_BIT] = wsel_q;
      rdata[CFG_FAIL_BIT] = fail_q;
    end
    else if (hit_os)
      rdata[NUM_CH-1:0] = out_q;
  end
  assign prdata       = rdata;
  assign pready       = 1'b1;
  assign pslverr      = acc && !mapped;
  assign out_on_o     = out_q;
  assign high_overcurrent_window_start_o = high_overcurrent_window_q;

  // checks
  a_loaddump_off: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ld_s |=> out_on_o == '0) else $error("output on during load dump");
  a_pump_off: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    cp_f |=> out_on_o == '0 && cp_q) else $error("pump fault not handled");
  a_uv_report: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    uv_f |=> uv_q && device_fault_summary && out_on_o == '0) else $error("undervoltage not reported");
  a_ov_report: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ov_f |=> ov_q && device_fault_summary) else $error("overvoltage not reported");
  a_uv_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    uv_q && !rd_ds |=> uv_q) else $error("undervoltage flag lost");
  a_cp_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    cp_q && !rd_qs |=> cp_q) else $error("pump flag lost");
  a_ts_off: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ts_f[0] |=> !out_on_o[0]) else $error("shutdown output still on");
  a_fail_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    fail_q && ts_lock_q[0] && !mode_change_i |=> ts_lock_q[0])
    else $error("fail mode restart without mode change");
endmodule : fps_supervisor

//--- test_fps_supervisor.sv
`timescale 1ns/10ps
module test_fps_supervisor
  import fps_pkg::*;
;
  logic              core_clk_i, rst_n_i, psel, penable, pwrite, pready, pslverr;
  logic              uv_i, ov_i, load_dump_i, pump_bad_i, fail_mode_i, mode_change_i;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, rdat;
  logic [NUM_CH-1:0] warn_hi_i, warn_lo_i, temp_shut_i, out_on_o, high_overcurrent_window_start_o;
  logic              err_q;
  int                err_total, check_count;
  logic [31:0]       row_in [4] = '{32'h0000_00ff, 32'hffff_ffe0, 32'h0a, 32'h1f};
  logic [4:0]        row_out[4] = '{5'h1f, 5'h00, 5'h0a, 5'h1f};

  fps_supervisor #(.RESTART_CYCLES(50)) fps_supervisor_inst (.core_clk_i, .rst_n_i,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .warn_hi_i, .warn_lo_i, .temp_shut_i, .uv_i, .ov_i, .load_dump_i, .pump_bad_i,
    .fail_mode_i, .mode_change_i, .out_on_o, .high_overcurrent_window_start_o);
  fps_mcu_model fps_mcu_model_inst (.core_clk_i, .prdata, .pready, .pslverr,
    .psel, .penable, .pwrite, .paddr, .pwdata);

  initial
  begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    fps_mcu_model_inst.xfer(1'b1, a, d, rdat, err_q);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    fps_mcu_model_inst.xfer(1'b0, a, 32'h0, rdat, err_q);
  endtask : rd
  // outputs are registered: let the edge that launches them pass first
  task automatic chko(input logic [4:0] e);
    cyc(1);
    chk({27'h0, out_on_o}, {27'h0, e});
  endtask : chko
  // select a channel, read its status, compare warn and shutdown bits
  task automatic chst(input int ch, input logic [1:0] e);
    wr(REG_CH_STAT, 32'(ch) << CH_SEL_LSB);
    rd(REG_CH_STAT);
    chk({30'h0, rdat[1:0]}, {30'h0, e});
  endtask : chst
  task automatic complete_run;
    if (err_total == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  initial
  begin
    #400000;
    err_total++;
    complete_run();
  end

  initial
  begin
    {rst_n_i, uv_i, ov_i, load_dump_i, pump_bad_i, fail_mode_i, mode_change_i} <= '0;
    {warn_hi_i, warn_lo_i, temp_shut_i} <= '0;
    cyc(2);
    rst_n_i <= 1'b1;
    cyc(1);
    chko(5'h00);
    rd(REG_QUICK_STAT);
    chk(rdat, 32'h0);
    rd(8'h1c);
    chk({31'h0, err_q}, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      wr(REG_OUT_CTRL, row_in[i]);
      chko(row_out[i]);
    end
    warn_hi_i[1] <= 1'b1;
    cyc(TEMP_DGL_CYC + 8);
    chko(5'h1f);
    rd(REG_QUICK_STAT);
    chk({27'h0, rdat[4:0]}, 32'h02);
    chst(1, 2'b01);
    warn_hi_i[1] <= 1'b0;
    cyc(4);
    chst(1, 2'b01);
    chst(1, 2'b00);
    warn_lo_i[3] <= 1'b1;
    cyc(4);
    chst(3, 2'b00);
    wr(REG_CONFIG, 32'h1);
    cyc(TEMP_DGL_CYC + 8);
    warn_lo_i[3] <= 1'b0;
    cyc(4);
    chst(3, 2'b01);
    chst(3, 2'b00);
    temp_shut_i[2] <= 1'b1;
    cyc(TEMP_DGL_CYC - 10);
    chko(5'h1f);
    cyc(20);
    chko(5'h1b);
    rd(REG_QUICK_STAT);
    chk({27'h0, rdat[12:8]}, 32'h04);
    temp_shut_i[2] <= 1'b0;
    cyc(5);
    chko(5'h1b);
    chst(2, 2'b10);
    chst(2, 2'b00);
    wr(REG_CH_CTRL, 32'h201);
    chko(5'h1f);
    uv_i <= 1'b1;
    cyc(SUPPLY_DGL_CYC + 8);
    chko(5'h00);
    rd(REG_DEV_STAT);
    chk(rdat & 32'h8000_0003, 32'h8000_0001);
    uv_i <= 1'b0;
    cyc(4);
    chko(5'h00);
    rd(REG_DEV_STAT);
    chk(rdat & 32'h1, 32'h1);
    rd(REG_DEV_STAT);
    chk(rdat & 32'h1, 32'h0);
    wr(REG_OUT_CTRL, 32'h1f);
    chko(5'h1f);
    ov_i <= 1'b1;
    cyc(SUPPLY_DGL_CYC + 8);
    rd(REG_DEV_STAT);
    chk(rdat & 32'h8000_0003, 32'h8000_0002);
    ov_i <= 1'b0;
    cyc(4);
    rd(REG_DEV_STAT);
    rd(REG_DEV_STAT);
    chk(rdat & 32'h3, 32'h0);
    load_dump_i <= 1'b1;
    cyc(SUPPLY_DGL_CYC + 8);
    chko(5'h00);
    load_dump_i <= 1'b0;
    pump_bad_i <= 1'b1;
    cyc(PUMP_DGL_CYC + 8);
    chko(5'h00);
    rd(REG_QUICK_STAT);
    chk(rdat & 32'h8001_0000, 32'h8001_0000);
    pump_bad_i <= 1'b0;
    cyc(5);
    chk({27'h0, high_overcurrent_window_start_o}, 32'h1f);
    chko(5'h1f);
    chk({27'h0, high_overcurrent_window_start_o}, 32'h0);
    rd(REG_QUICK_STAT);
    rd(REG_QUICK_STAT);
    chk(rdat & 32'h1_0000, 32'h0);
    fail_mode_i <= 1'b1;
    uv_i <= 1'b1;
    cyc(SUPPLY_DGL_CYC + 8);
    uv_i <= 1'b0;
    cyc(40);
    chko(5'h00);
    cyc(20);
    chko(5'h1f);
    temp_shut_i[0] <= 1'b1;
    cyc(TEMP_DGL_CYC + 8);
    temp_shut_i[0] <= 1'b0;
    cyc(60);
    chko(5'h1e);
    wr(REG_OUT_CTRL, 32'h1f);
    chko(5'h1e);
    mode_change_i <= 1'b1;
    cyc(1);
    mode_change_i <= 1'b0;
    cyc(4);
    chko(5'h1f);
    // mid-run reset drops outputs and latched flags
    rst_n_i <= 1'b0;
    cyc(2);
    rst_n_i <= 1'b1;
    chko(5'h00);
    rd(REG_DEV_STAT);
    chk(rdat, 32'h0);
    complete_run();
  end
endmodule : test_fps_supervisor
